/* core/harc_pkg.sv */
// package: constants and carriers for the host remap and config block
package harc_pkg;
  // i/o ports decoded by the block
  localparam logic [15:0] IO_INDEX = 16'h0022;
  localparam logic [15:0] IO_DATA = 16'h0023;
  localparam logic [15:0] IO_VGA_MB = 16'h0094;
  localparam logic [15:0] IO_VGA_ADDIN = 16'h46e8;
  localparam logic [15:0] IO_CFG_ADDR = 16'h0cf8;
  localparam logic [15:0] IO_CFG_DATA = 16'h0cfc;
  // indexed configuration registers
  localparam logic [7:0] IDX_CACHE_ARCH0 = 8'h20;
  localparam logic [7:0] IDX_GFX_MEM_SIZE = 8'h36;
  // pci configuration header byte offsets and own device number
  localparam logic [7:0] PCI_VENDOR_OFS = 8'h00;
  localparam logic [7:0] PCI_DEVICE_OFS = 8'h02;
  localparam logic [7:0] PCI_COMMAND_OFS = 8'h04;
  localparam logic [7:0] PCI_STATUS_OFS = 8'h06;
  localparam logic [7:0] PCI_REVISION_OFS = 8'h08;
  localparam logic [7:0] PCI_CONTROL_OFS = 8'h40;
  localparam logic [4:0] PCI_OWN_DEVICE = 5'h00;
  // reset values
  localparam logic [7:0] CACHE_ARCH0_RST = 8'h00;
  localparam logic [7:0] GFX_MEM_SIZE_RST = 8'h00;
  localparam logic [15:0] PCI_COMMAND_RST = 16'h0000;
  localparam logic [7:0] PCI_CONTROL_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  // memory map figures
  localparam logic [31:0] FB_DRAM_BASE = 32'h0000_0000;
  localparam int GFX_UNIT_SHIFT = 17;
  localparam logic [31:0] BIOS_AREA_LO = 32'h000d_0000;
  localparam logic [31:0] BIOS_AREA_HI = 32'h000e_ffff;
  localparam logic [31:0] RECLAIM_SIZE = 32'h0002_0000;
  localparam logic [31:0] RECLAIM_NONE = 32'h0000_0000;
  localparam logic [1:0] SRAM_RESERVED = 2'h3;

  // first cache architecture register layout
  typedef struct packed {
    logic pipelined_host_access_support;
    logic burst_order_select;
    logic first_level_writeback_flag;
    logic [1:0] sram_type;
    logic second_level_bank_count;
    logic second_level_write_policy;
    logic second_level_cache_enable;
  } harc_cache_t;

  // host i/o cycle request
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } harc_io_req_t;

  // translated memory cycle
  typedef struct packed {
    logic valid;
    logic to_dram;
    logic to_bus;
    logic [31:0] dram_addr;
  } harc_map_t;

  // memory map settings supplied by neighbouring controller logic
  typedef struct packed {
    logic [31:0] dram_total;
    logic hole_enable;
    logic [31:0] hole_base;
    logic [31:0] hole_size;
    logic [7:0] bios_shadow_en;
  } harc_mapcfg_t;
endpackage

/* core/harc_top.sv */
// host address remap, i/o decode, pci header and cache arch register
`timescale 1ns/1ps
module harc_top #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
  parameter logic [15:0] STATUS_VALUE = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire harc_pkg::harc_io_req_t io_req,
  output logic io_ack,
  output logic io_claim,
  output logic [7:0] io_rdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire harc_pkg::harc_mapcfg_t map_cfg,
  output harc_pkg::harc_map_t map_out,
  output logic [31:0] reclaimed_bios_area_size,
  input wire logic mb_video_strap,
  output harc_pkg::harc_cache_t cache_cfg,
  output logic l2_interleave,
  output logic [15:0] pci_command,
  output logic [7:0] pci_chip_control,
  output logic [7:0] vga_mb_enable,
  output logic [7:0] vga_addin_enable
);

  typedef struct packed {
    logic strap_meta;
    logic strap_q;
    logic [7:0] index;
    harc_pkg::harc_cache_t cache;
    logic [7:0] gfx_size;
    logic [31:0] cfg_addr;
    logic [15:0] command;
    logic [7:0] control;
    logic [7:0] vga_mb;
    logic [7:0] vga_addin;
    logic ack;
    logic claim;
    logic [7:0] rdata;
    harc_pkg::harc_map_t map;
    logic [31:0] reclaim;
  } harc_state_t;

  harc_state_t cur;
  harc_state_t next_cur;

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // one byte of the pci header at byte offset ofs
  function automatic logic [7:0] header_byte(input logic [7:0] ofs,
                                             input logic [15:0] cmd,
                                             input logic [7:0] ctl);
    header_byte = 8'h00;
    case (ofs)
      harc_pkg::PCI_VENDOR_OFS: header_byte = VENDOR_ID[7:0];
      harc_pkg::PCI_VENDOR_OFS + 8'h01: header_byte = VENDOR_ID[15:8];
      harc_pkg::PCI_DEVICE_OFS: header_byte = DEVICE_ID[7:0];
      harc_pkg::PCI_DEVICE_OFS + 8'h01: header_byte = DEVICE_ID[15:8];
      harc_pkg::PCI_COMMAND_OFS: header_byte = cmd[7:0];
      harc_pkg::PCI_COMMAND_OFS + 8'h01: header_byte = cmd[15:8];
      harc_pkg::PCI_STATUS_OFS: header_byte = STATUS_VALUE[7:0];
      harc_pkg::PCI_STATUS_OFS + 8'h01: header_byte = STATUS_VALUE[15:8];
      harc_pkg::PCI_REVISION_OFS: header_byte = REVISION_ID;
      harc_pkg::PCI_CONTROL_OFS: header_byte = ctl;
      default: header_byte = 8'h00;
    endcase
  endfunction

  logic io_rd;
  logic io_wr;
  logic hit_index;
  logic hit_data;
  logic hit_cfg_addr;
  logic hit_cfg_data;
  logic hit_vga_mb;
  logic hit_vga_addin;
  logic cfg_target_me;
  logic [7:0] hdr_ofs;
  logic [31:0] fb_size;
  logic [31:0] sys_top;
  logic [31:0] hole_end;
  logic in_hole;
  logic [31:0] eff_addr;
  logic [31:0] reclaim_now;
  logic in_bios;
  logic [2:0] bios_seg;

  always_comb begin
    io_rd = io_req.req && !io_req.wr;
    io_wr = io_req.req && io_req.wr;
    hit_index = io_req.addr == harc_pkg::IO_INDEX;
    hit_data = io_req.addr == harc_pkg::IO_DATA;
    hit_cfg_addr = io_req.addr[15:2] == harc_pkg::IO_CFG_ADDR[15:2];
    hit_cfg_data = io_req.addr[15:2] == harc_pkg::IO_CFG_DATA[15:2];
    hit_vga_mb = (io_req.addr == harc_pkg::IO_VGA_MB) && cur.strap_q;
    hit_vga_addin = (io_req.addr == harc_pkg::IO_VGA_ADDIN)
                    && cur.strap_q;
    // enable bit set, bus 0, device 0, function 0
    cfg_target_me = cur.cfg_addr[31] && (cur.cfg_addr[23:16] == 8'h00)
                    && (cur.cfg_addr[15:11] == harc_pkg::PCI_OWN_DEVICE)
                    && (cur.cfg_addr[10:8] == 3'h0);
    hdr_ofs = {cur.cfg_addr[7:2], io_req.addr[1:0]};

    // memory map arithmetic
    fb_size = {24'h000000, cur.gfx_size} << harc_pkg::GFX_UNIT_SHIFT;
    sys_top = map_cfg.dram_total - fb_size;
    hole_end = map_cfg.hole_base + map_cfg.hole_size;
    in_hole = map_cfg.hole_enable && (mem_addr >= map_cfg.hole_base)
              && (mem_addr < hole_end);
    eff_addr = (map_cfg.hole_enable && (mem_addr >= hole_end))
               ? mem_addr - map_cfg.hole_size : mem_addr;
    reclaim_now = (map_cfg.bios_shadow_en == 8'h00)
                  ? harc_pkg::RECLAIM_SIZE : harc_pkg::RECLAIM_NONE;
    in_bios = in_range(eff_addr, harc_pkg::BIOS_AREA_LO,
                       harc_pkg::BIOS_AREA_HI);
    bios_seg = 3'((eff_addr - harc_pkg::BIOS_AREA_LO) >> 14);

    next_cur = cur;
    next_cur.strap_meta = mb_video_strap;
    next_cur.strap_q = cur.strap_meta;
    next_cur.ack = io_req.req;
    next_cur.claim = 1'b0;
    next_cur.rdata = 8'h00;
    next_cur.reclaim = reclaim_now;

    // i/o decode
    if (io_req.req) begin
      if (hit_index) begin
        next_cur.claim = 1'b1;
        next_cur.rdata = cur.index;
        if (io_wr) begin
          next_cur.index = io_req.wdata;
        end
      end else if (hit_data) begin
        next_cur.claim = 1'b1;
        // data port always follows the last written index
        case (cur.index)
          harc_pkg::IDX_CACHE_ARCH0: begin
            next_cur.rdata = cur.cache;
            if (io_wr) begin
              next_cur.cache = io_req.wdata;
              if (io_req.wdata[4:3] == harc_pkg::SRAM_RESERVED) begin
                next_cur.cache.sram_type = cur.cache.sram_type;
              end
            end
          end
          harc_pkg::IDX_GFX_MEM_SIZE: begin
            next_cur.rdata = cur.gfx_size;
            if (io_wr) begin
              next_cur.gfx_size = io_req.wdata;
            end
          end
          default: next_cur.rdata = 8'h00;
        endcase
      end else if (hit_cfg_addr) begin
        next_cur.claim = 1'b1;
        next_cur.rdata = cur.cfg_addr[8*io_req.addr[1:0] +: 8];
        if (io_wr) begin
          next_cur.cfg_addr[8*io_req.addr[1:0] +: 8] = io_req.wdata;
        end
      end else if (hit_cfg_data && cfg_target_me) begin
        next_cur.claim = 1'b1;
        next_cur.rdata = header_byte(hdr_ofs, cur.command,
                                     cur.control);
        if (io_wr) begin
          if (hdr_ofs == harc_pkg::PCI_COMMAND_OFS) begin
            next_cur.command[7:0] = io_req.wdata;
          end
          if (hdr_ofs == harc_pkg::PCI_COMMAND_OFS + 8'h01) begin
            next_cur.command[15:8] = io_req.wdata;
          end
          if (hdr_ofs == harc_pkg::PCI_CONTROL_OFS) begin
            next_cur.control = io_req.wdata;
          end
        end
      end else if (hit_vga_mb) begin
        next_cur.claim = 1'b1;
        next_cur.rdata = cur.vga_mb;
        if (io_wr) begin
          next_cur.vga_mb = io_req.wdata;
        end
      end else if (hit_vga_addin) begin
        next_cur.claim = 1'b1;
        next_cur.rdata = cur.vga_addin;
        if (io_wr) begin
          next_cur.vga_addin = io_req.wdata;
        end
      end
    end

    // memory translation
    next_cur.map.valid = mem_req;
    next_cur.map.to_dram = 1'b0;
    next_cur.map.to_bus = 1'b0;
    next_cur.map.dram_addr = cur.map.dram_addr;
    if (mem_req) begin
      if (in_hole) begin
        next_cur.map.to_bus = 1'b1;
      end else if (in_bios && !map_cfg.bios_shadow_en[bios_seg]) begin
        next_cur.map.to_bus = 1'b1;
      end else if (eff_addr < sys_top) begin
        next_cur.map.to_dram = 1'b1;
        next_cur.map.dram_addr = harc_pkg::FB_DRAM_BASE + fb_size
                                 + eff_addr;
      end else if (eff_addr < sys_top + reclaim_now) begin
        // top slice lands on the dram hidden behind the bios area
        next_cur.map.to_dram = 1'b1;
        next_cur.map.dram_addr = fb_size + harc_pkg::BIOS_AREA_LO
                                 + (eff_addr - sys_top);
      end else begin
        next_cur.map.to_bus = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.index <= harc_pkg::INDEX_RST;
      cur.cache <= harc_pkg::CACHE_ARCH0_RST;
      cur.gfx_size <= harc_pkg::GFX_MEM_SIZE_RST;
      cur.command <= harc_pkg::PCI_COMMAND_RST;
      cur.control <= harc_pkg::PCI_CONTROL_RST;
      cur.reclaim <= harc_pkg::RECLAIM_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  assign io_ack = cur.ack;
  assign io_claim = cur.claim;
  assign io_rdata = cur.rdata;
  assign map_out = cur.map;
  assign reclaimed_bios_area_size = cur.reclaim;
  assign cache_cfg = cur.cache;
  assign l2_interleave = cur.cache.second_level_bank_count;
  assign pci_command = cur.command;
  assign pci_chip_control = cur.control;
  assign vga_mb_enable = cur.vga_mb;
  assign vga_addin_enable = cur.vga_addin;

  io_answer_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req |=> io_ack)
    else $error("i/o request not answered next cycle");

  index_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && io_req.wr && io_req.addr == 16'h0022
    |=> cur.index == $past(io_req.wdata) && io_claim)
    else $error("index port write not stored");

  index_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && !io_req.wr && io_req.addr == 16'h0022
    |=> io_claim && io_rdata == $past(cur.index))
    else $error("index port read wrong");

  cache_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && io_req.wr && io_req.addr == 16'h0023
    && cur.index == 8'h20 && io_req.wdata[4:3] != 2'h3
    |=> cache_cfg == $past(io_req.wdata))
    else $error("cache arch register write lost");

  sram_reserved_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && io_req.wr && io_req.addr == 16'h0023
    && cur.index == 8'h20 && io_req.wdata[4:3] == 2'h3
    |=> cache_cfg.sram_type == $past(cache_cfg.sram_type))
    else $error("reserved sram type accepted");

  strap_claim_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && (io_req.addr == 16'h0094 || io_req.addr == 16'h46e8)
    |=> io_claim == $past(cur.strap_q))
    else $error("video port claim ignores strap");

  cfg_addr_claim_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && io_req.addr[15:2] == 14'h033e
    |=> io_ack && io_claim)
    else $error("config address port not claimed");

  cfg_disabled_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    io_req.req && io_req.addr[15:2] == 14'h033f && !cur.cfg_addr[31]
    |=> io_ack && !io_claim)
    else $error("config data claimed while disabled");

  hole_route_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    mem_req && in_hole |=> map_out.valid && map_out.to_bus
    && !map_out.to_dram)
    else $error("hole cycle reached dram");

  fb_offset_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    mem_req && !map_cfg.hole_enable && !in_bios && mem_addr < sys_top
    |=> map_out.to_dram
    && map_out.dram_addr == $past(mem_addr) + $past(fb_size))
    else $error("dram address not above frame buffer");

  hole_skip_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    mem_req && map_cfg.hole_enable && mem_addr >= hole_end
    && mem_addr - map_cfg.hole_size < sys_top && !in_bios
    |=> map_out.dram_addr == $past(mem_addr) - $past(map_cfg.hole_size)
    + $past(fb_size))
    else $error("address past hole not lowered");

  bios_bus_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    mem_req && (!map_cfg.hole_enable || mem_addr < map_cfg.hole_base)
    && mem_addr >= 32'h000d_0000 && mem_addr <= 32'h000e_ffff
    && map_cfg.bios_shadow_en == 8'h00
    |=> map_out.to_bus && !map_out.to_dram)
    else $error("unshadowed bios cycle reached dram");

  reclaim_size_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    map_cfg.bios_shadow_en != 8'h00
    |=> reclaimed_bios_area_size == 32'h0)
    else $error("reclaim given while bios shadowed");

  reclaim_full_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    map_cfg.bios_shadow_en == 8'h00 && !$past(rst)
    |=> reclaimed_bios_area_size == 32'h0002_0000)
    else $error("reclaim missing while bios unshadowed");

endmodule

/* tb/harc_host_model.sv */
// host processor model issuing i/o and memory translate cycles
`timescale 1ns/1ps
module harc_host_model (
  input wire logic sys_clk,
  output harc_pkg::harc_io_req_t io_req,
  input wire logic io_ack,
  input wire logic io_claim,
  input wire logic [7:0] io_rdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire harc_pkg::harc_map_t map_out
);
  initial begin
    io_req = '0;
    mem_req = 1'b0;
    mem_addr = 32'h0;
  end

  // one-cycle request; released lines show the inverse of the last value
  task automatic io_cycle(input logic wr, input logic [15:0] a,
                          input logic [7:0] d, output logic ack,
                          output logic claim, output logic [7:0] rd);
    @(posedge sys_clk);
    io_req <= '{req: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    io_req <= '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
    @(posedge sys_clk);
    ack = io_ack;
    claim = io_claim;
    rd = io_rdata;
  endtask

  // one translate request; the answer is taken one edge after
  task automatic mem_cycle(input logic [31:0] a,
                           output harc_pkg::harc_map_t m);
    @(posedge sys_clk);
    mem_req <= 1'b1;
    mem_addr <= a;
    @(posedge sys_clk);
    mem_req <= 1'b0;
    mem_addr <= ~a;
    @(posedge sys_clk);
    m = map_out;
  endtask
endmodule

/* tb/test_host_address_remap_cache_cfg.sv */
// testbench for the host remap and config block
`timescale 1ns/1ps
module test_host_address_remap_cache_cfg;
  localparam logic [15:0] VID = 16'h4a5b; // arbitrary value
  localparam logic [15:0] DID = 16'h6c7d; // arbitrary value
  localparam logic [7:0] REV = 8'h3e; // arbitrary value
  logic sys_clk;
  logic rst;
  logic mb_video_strap;
  harc_pkg::harc_io_req_t io_req;
  logic io_ack;
  logic io_claim;
  logic [7:0] io_rdata;
  logic mem_req;
  logic [31:0] mem_addr;
  harc_pkg::harc_mapcfg_t map_cfg;
  harc_pkg::harc_map_t map_out;
  logic [31:0] reclaim;
  harc_pkg::harc_cache_t cache_cfg;
  logic l2_interleave;
  logic [15:0] pci_command;
  logic [7:0] pci_chip_control;
  int n_fail;
  int checked;
  logic [7:0] vga_mb_en;
  logic [7:0] vga_addin_en;
  logic [7:0] idx_m;
  logic [7:0] cache_m;
  logic [31:0] cfg_m;

  harc_top #(.VENDOR_ID(VID), .DEVICE_ID(DID), .REVISION_ID(REV),
    .STATUS_VALUE(16'h0000)) u_harc_top (.sys_clk(sys_clk), .rst(rst),
    .io_req(io_req), .io_ack(io_ack), .io_claim(io_claim),
    .io_rdata(io_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
    .map_cfg(map_cfg), .map_out(map_out),
    .reclaimed_bios_area_size(reclaim), .mb_video_strap(mb_video_strap),
    .cache_cfg(cache_cfg), .l2_interleave(l2_interleave),
    .pci_command(pci_command), .pci_chip_control(pci_chip_control),
    .vga_mb_enable(vga_mb_en), .vga_addin_enable(vga_addin_en));

  harc_host_model u_host (.sys_clk(sys_clk), .io_req(io_req),
    .io_ack(io_ack), .io_claim(io_claim), .io_rdata(io_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .map_out(map_out));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d,
                    input logic c, input logic [7:0] r, input string what);
    logic k;
    logic cl;
    logic [7:0] rd;
    u_host.io_cycle(wr, a, d, k, cl, rd);
    chk({what, " ack"}, 32'h1, {31'h0, k});
    chk({what, " claim"}, {31'h0, c}, {31'h0, cl});
    chk({what, " data"}, {24'h0, r}, {24'h0, rd});
  endtask

  // a write answers with the value the register held before it
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] old;
    old = (idx == harc_pkg::IDX_CACHE_ARCH0) ? cache_m : 8'h00;
    io(1'b1, harc_pkg::IO_INDEX, idx, 1'b1, idx_m, "index");
    idx_m = idx;
    io(1'b1, harc_pkg::IO_DATA, d, 1'b1, old, "data write");
    if (idx == harc_pkg::IDX_CACHE_ARCH0) begin
      cache_m = d;
      if (d[4:3] == harc_pkg::SRAM_RESERVED) begin
        cache_m[4:3] = old[4:3];
      end
    end
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] r);
    io(1'b1, harc_pkg::IO_INDEX, idx, 1'b1, idx_m, "index");
    idx_m = idx;
    io(1'b0, harc_pkg::IO_DATA, 8'h00, 1'b1, r, "data read");
  endtask

  task automatic cfg_sel(input logic [31:0] a);
    logic [7:0] old;
    for (int i = 0; i < 4; i++) begin
      old = cfg_m[8*i+:8];
      io(1'b1, 16'h0cf8 + 16'(i), a[8*i+:8], 1'b1, old, "cfg addr");
      cfg_m[8*i+:8] = a[8*i+:8];
    end
  endtask

  task automatic mem(input logic [31:0] a, input logic d,
                     input logic [31:0] x);
    harc_pkg::harc_map_t m;
    u_host.mem_cycle(a, m);
    chk("map valid", 32'h1, {31'h0, m.valid});
    chk("to dram", {31'h0, d}, {31'h0, m.to_dram});
    chk("to bus", {31'h0, ~d}, {31'h0, m.to_bus});
    if (d) begin
      chk("dram addr", x, m.dram_addr);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    idx_m = 8'h00;
    cache_m = 8'h00;
    cfg_m = 32'h0;
    rst = 1'b1;
    mb_video_strap = 1'b0;
    map_cfg = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    reg_rd(harc_pkg::IDX_CACHE_ARCH0, 8'h00);
    io(1'b0, harc_pkg::IO_INDEX, 8'h00, 1'b1, 8'h20, "index read");
    for (int b = 0; b < 8; b++) begin
      if (b != 3 && b != 4) begin
        reg_wr(harc_pkg::IDX_CACHE_ARCH0, 8'h01 << b);
        chk("cache", 32'h1 << b, {24'h0, cache_cfg});
        chk("interleave", {31'h0, b == 2}, {31'h0, l2_interleave});
        reg_rd(harc_pkg::IDX_CACHE_ARCH0, 8'h01 << b);
      end
    end
    for (int t = 0; t < 3; t++) begin
      reg_wr(harc_pkg::IDX_CACHE_ARCH0, {3'h0, 2'(t), 3'h0});
      chk("sram type", {27'h0, 2'(t), 3'h0}, {24'h0, cache_cfg});
    end
    reg_wr(harc_pkg::IDX_CACHE_ARCH0, 8'h9f);
    chk("sram reserved", 32'h97, {24'h0, cache_cfg});
    cfg_sel(32'h8000_0000);
    io(1'b0, 16'h0cfc, 8'h00, 1'b1, VID[7:0], "vendor lo");
    io(1'b0, 16'h0cfd, 8'h00, 1'b1, VID[15:8], "vendor hi");
    io(1'b0, 16'h0cfe, 8'h00, 1'b1, DID[7:0], "device lo");
    io(1'b0, 16'h0cff, 8'h00, 1'b1, DID[15:8], "device hi");
    cfg_sel(32'h8000_0004);
    io(1'b1, 16'h0cfc, 8'h07, 1'b1, 8'h00, "command lo");
    io(1'b1, 16'h0cfd, 8'h01, 1'b1, 8'h00, "command hi");
    chk("command", 32'h0107, {16'h0, pci_command});
    io(1'b0, 16'h0cfe, 8'h00, 1'b1, 8'h00, "status");
    cfg_sel(32'h8000_0008);
    io(1'b0, 16'h0cfc, 8'h00, 1'b1, REV, "revision");
    cfg_sel(32'h8000_0040);
    io(1'b1, 16'h0cfc, 8'ha5, 1'b1, 8'h00, "control wr");
    io(1'b0, 16'h0cfc, 8'h00, 1'b1, 8'ha5, "control rd");
    chk("control", 32'ha5, {24'h0, pci_chip_control});
    cfg_sel(32'h0000_0040);
    io(1'b0, 16'h0cfc, 8'h00, 1'b0, 8'h00, "cfg disabled");
    cfg_sel(32'h8000_0800);
    io(1'b0, 16'h0cfc, 8'h00, 1'b0, 8'h00, "other device");
    io(1'b0, 16'h0300, 8'h00, 1'b0, 8'h00, "unmapped");
    io(1'b0, harc_pkg::IO_VGA_MB, 8'h00, 1'b0, 8'h00, "mb vga off");
    io(1'b0, harc_pkg::IO_VGA_ADDIN, 8'h00, 1'b0, 8'h00, "addin off");
    mb_video_strap <= 1'b1;
    repeat (3) @(posedge sys_clk);
    io(1'b0, harc_pkg::IO_VGA_MB, 8'h00, 1'b1, 8'h00, "mb vga on");
    io(1'b0, harc_pkg::IO_VGA_ADDIN, 8'h00, 1'b1, 8'h00, "addin on");
    io(1'b1, harc_pkg::IO_VGA_MB, 8'h5a, 1'b1, 8'h00, "mb vga wr");
    chk("mb vga enable", 32'h5a, {24'h0, vga_mb_en});
    io(1'b1, harc_pkg::IO_VGA_ADDIN, 8'hc3, 1'b1, 8'h00, "addin wr");
    chk("addin enable", 32'hc3, {24'h0, vga_addin_en});
    reg_wr(harc_pkg::IDX_GFX_MEM_SIZE, 8'h02);
    map_cfg <= '{dram_total: 32'h40_0000, hole_enable: 1'b0,
      hole_base: 32'h20_0000, hole_size: 32'h10_0000, bios_shadow_en: 8'h00};
    mem(32'h1000, 1'b1, 32'h4_1000);
    mem(32'h25_0000, 1'b1, 32'h29_0000);
    map_cfg.hole_enable <= 1'b1;
    mem(32'h25_0000, 1'b0, 32'h0);
    mem(32'h30_0000, 1'b1, 32'h24_0000);
    mem(32'hd_0000, 1'b0, 32'h0);
    mem(32'h4c_0010, 1'b1, 32'h11_0010);
    mem(32'h4e_0000, 1'b0, 32'h0);
    chk("reclaim", 32'h2_0000, reclaim);
    for (int b = 0; b < 8; b++) begin
      map_cfg.bios_shadow_en <= 8'h01 << b;
      repeat (2) @(posedge sys_clk);
      chk("reclaim shadowed", 32'h0, reclaim);
    end
    map_cfg.bios_shadow_en <= 8'h01;
    mem(32'h4c_0010, 1'b0, 32'h0);
    mem(32'hd_0000, 1'b1, 32'h11_0000);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    idx_m = 8'h00;
    cache_m = 8'h00;
    reg_rd(harc_pkg::IDX_CACHE_ARCH0, 8'h00);
    chk("cache after reset", 32'h0, {24'h0, cache_cfg});
    end_of_test();
  end
endmodule
